//--- src/adcr_device.sv
/*
  Converter end of the serial readout link: track/hold control, frame
  shifter, result output enable and normal/shutdown mode logic.
  Assumes chip select and serial clock arrive asynchronously from the
  host and are oversampled by core_clk (serial clock well below core_clk/4).
*/
// Function
// RQ1: Chip-select fall starts one conversion
// RQ2: Chip-select fall enables the result output
// RQ3: Chip-select fall samples input, enters hold
// RQ4: Thirteenth rising clock returns to track
// RQ5: Edges counted from chip-select fall
// RQ6: Host allows 350 ns acquisition
// RQ7: Float output after sixteenth fall or rise
// RQ8: Host waits quiet time before next start
// RQ9: Host gives sixteen clocks per sample
// RQ10: Bits change and are captured on falls
// RQ11: Three zeros, then twelve bits MSB first
// RQ12: Host tolerates an extra leading zero
// RQ13: Host uses twenty-clock frames
// RQ14: Host keeps minimum chip-select fall spacing
// RQ15: Result is unsigned straight binary
// RQ16: Result spans 4096 codes
// RQ17: Chip-select fall selects normal mode
// RQ18: Rise before tenth fall enters shutdown
// RQ19: Shutdown holds until next chip-select fall
// RQ20: No minimum conversion rate
// RQ21: Rise before second fall keeps mode
// RQ22: Rise between tenth and sixteenth aborts
// RQ23: Host drops first result after shutdown
// RQ24: Host keeps low twelve captured bits
`timescale 1ns/1ns
`default_nettype none
module adcr_device
  import adcr_pkg::*;
#(
  parameter int RES_W = RESULT_BITS
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Link to the host
  adcr_link_if.device link,
  // Converter core
  input wire logic [RES_W-1:0] sample_code,
  output logic sample_taken,
  output logic hold_active,
  output logic shutdown_active,
  output logic result_invalid,
  output logic frame_aborted
);

  localparam int PAD_W = FRAME_BITS - RES_W;

  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_prev_reg;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic in_frame;
  adcr_dev_state_type state_reg;
  logic [CNT_W-1:0] fall_cnt_reg;
  logic [CNT_W-1:0] rise_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic oe_reg;
  logic shutdown_reg;
  logic prev_mode_reg;
  logic hold_reg;
  logic taken_reg;
  logic invalid_reg;
  logic abort_reg;

  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] value);
    count_up = (value == CNT_MAX) ? value : value + 5'h01;
  endfunction

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      sclk_meta_reg <= 1'b1;
      sclk_sync_reg <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else if (clk_en) begin
      cs_meta_reg <= link.cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      sclk_meta_reg <= link.sclk;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end

  assign cs_fall = cs_prev_reg & ~cs_sync_reg;
  assign cs_rise = ~cs_prev_reg & cs_sync_reg;
  // Clock edges only count while selected and not in the start cycle
  assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg & ~cs_sync_reg & ~cs_fall;
  assign sclk_rise = ~sclk_prev_reg & sclk_sync_reg & ~cs_sync_reg & ~cs_fall;
  assign in_frame = (state_reg == DEV_HOLD) || (state_reg == DEV_TRACK);

  // Frame phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= DEV_IDLE;
    end else if (clk_en) begin
      if (cs_fall) begin
        state_reg <= DEV_HOLD; // RQ1
      end else if (cs_rise) begin
        state_reg <= DEV_IDLE;
      end else begin
        case (state_reg)
          DEV_IDLE: begin
            state_reg <= DEV_IDLE; // RQ20
          end
          DEV_HOLD: begin
            if (sclk_rise && rise_cnt_reg == HOLD_RELEASE_RISE - 5'h01) begin
              state_reg <= DEV_TRACK; // RQ4
            end
          end
          DEV_TRACK: begin
            if (sclk_fall && fall_cnt_reg == FRAME_FALLS - 5'h01) begin
              state_reg <= DEV_DONE;
            end
          end
          DEV_DONE: begin
            state_reg <= DEV_DONE;
          end
          default: begin
            state_reg <= DEV_IDLE;
          end
        endcase
      end
    end
  end

  // Edge numbering restarts at every selection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fall_cnt_reg <= '0;
      rise_cnt_reg <= '0;
    end else if (clk_en) begin
      if (cs_fall) begin
        fall_cnt_reg <= '0; // RQ5
        rise_cnt_reg <= '0;
      end else if (state_reg != DEV_IDLE) begin
        if (sclk_fall) begin
          fall_cnt_reg <= count_up(fall_cnt_reg); // RQ5
        end
        if (sclk_rise) begin
          rise_cnt_reg <= count_up(rise_cnt_reg);
        end
      end
    end
  end

  // Track/hold switch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        hold_reg <= 1'b1; // RQ3
      end else if (cs_rise) begin
        hold_reg <= 1'b0;
      end else if (state_reg == DEV_HOLD && sclk_rise && rise_cnt_reg == HOLD_RELEASE_RISE - 5'h01) begin
        hold_reg <= 1'b0; // RQ4
      end
    end
  end

  // Frame shifter: pad zeros above an unsigned code, MSB leaves first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (clk_en) begin
      if (cs_fall) begin
        shift_reg <= {{PAD_W{1'b0}}, sample_code}; // RQ3 RQ11 RQ15 RQ16
      end else if (in_frame && sclk_fall) begin
        shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0}; // RQ10
      end
    end
  end

  // Output enable; whichever of sixteenth fall or deselect comes first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_reg <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        oe_reg <= 1'b1; // RQ2
      end else if (cs_rise) begin
        oe_reg <= 1'b0; // RQ7 RQ22
      end else if (sclk_fall && fall_cnt_reg == FRAME_FALLS - 5'h01) begin
        oe_reg <= 1'b0; // RQ7
      end
    end
  end

  // Power mode: a start wakes the part, an early deselect decides the rest
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shutdown_reg <= 1'b0;
      prev_mode_reg <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        prev_mode_reg <= shutdown_reg;
        shutdown_reg <= 1'b0; // RQ17
      end else if (cs_rise && state_reg != DEV_IDLE) begin
        if (fall_cnt_reg < GLITCH_FALLS) begin
          shutdown_reg <= prev_mode_reg; // RQ21
        end else if (fall_cnt_reg < NORMAL_KEEP_FALLS) begin
          shutdown_reg <= 1'b1; // RQ18
        end else begin
          shutdown_reg <= 1'b0; // RQ18 RQ22
        end
      end
      // Otherwise shutdown simply persists until the next start
    end
  end

  // Status towards the converter core
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      taken_reg <= 1'b0;
      invalid_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else if (clk_en) begin
      taken_reg <= cs_fall;
      abort_reg <= cs_rise && in_frame && fall_cnt_reg >= GLITCH_FALLS;
      if (cs_fall) begin
        // Waking from shutdown yields a dummy conversion
        invalid_reg <= shutdown_reg; // RQ19
      end
    end
  end

  assign link.serial_result_out_o = shift_reg[FRAME_BITS-1];
  assign link.serial_result_out_oe = oe_reg;
  assign sample_taken = taken_reg;
  assign hold_active = hold_reg;
  assign shutdown_active = shutdown_reg;
  assign result_invalid = invalid_reg;
  assign frame_aborted = abort_reg;

endmodule
`default_nettype wire

//--- src/adcr_host.sv
/*
  Host end of the serial readout link: clock divider, frame sequencer,
  bit capture and a result FIFO towards the user.
  Assumes the converter end sits on the shared link interface.
*/
`timescale 1ns/1ns
`default_nettype none
module adcr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (clk_en && in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (clk_en) begin
      if (in_valid && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module adcr_host
  import adcr_pkg::*;
#(
  parameter int RES_W = RESULT_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Link to the converter
  adcr_link_if.host link,
  // Conversion requests
  input wire logic conv_req,
  input wire logic conv_shutdown,
  output logic conv_ready,
  // Results
  output logic result_valid,
  input wire logic result_ready,
  output logic [RES_W-1:0] result_data
);

  adcr_host_state_type state_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic sd_meta_reg;
  logic sd_sync_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [CNT_W-1:0] fall_cnt_reg;
  logic [CNT_W-1:0] target_reg;
  logic [FRAME_BITS-1:0] capture_reg;
  logic shdn_frame_reg;
  logic discard_reg;
  logic push_reg;
  logic fifo_in_ready;
  logic ready_reg;
  logic tick;
  logic take;

  assign tick = timer_reg == '0;
  assign take = conv_req && ready_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end else if (clk_en) begin
      sd_meta_reg <= link.serial_result_out_line;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  // Sequencer; clock idles high so the first edge after a start falls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= HST_IDLE;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b1;
      timer_reg <= '0;
      fall_cnt_reg <= '0;
      target_reg <= HOST_FRAME_CLKS;
      shdn_frame_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        HST_IDLE: begin
          if (take) begin
            cs_n_reg <= 1'b0; // RQ1
            timer_reg <= TIMER_W'(SCLK_HALF_CYC - 1);
            fall_cnt_reg <= '0;
            shdn_frame_reg <= conv_shutdown;
            target_reg <= conv_shutdown ? SHDN_FRAME_FALLS : HOST_FRAME_CLKS; // RQ13 RQ18
            state_reg <= HST_CLOCKING;
          end
        end
        HST_CLOCKING: begin
          if (tick) begin
            timer_reg <= TIMER_W'(SCLK_HALF_CYC - 1);
            if (sclk_reg) begin
              sclk_reg <= 1'b0;
              fall_cnt_reg <= fall_cnt_reg + 5'h01;
            end else if (fall_cnt_reg == target_reg) begin
              sclk_reg <= 1'b1;
              cs_n_reg <= 1'b1; // RQ9 RQ14
              timer_reg <= TIMER_W'(ACQ_CYC + QUIET_CYC - 1);
              state_reg <= HST_QUIET;
            end else begin
              sclk_reg <= 1'b1;
            end
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        HST_QUIET: begin
          if (tick) begin
            state_reg <= HST_IDLE; // RQ6 RQ8
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  // Capture on each of the first sixteen falls the bit the converter set up one fall earlier
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == HST_CLOCKING && tick && sclk_reg && fall_cnt_reg < FRAME_FALLS) begin
        capture_reg <= {capture_reg[FRAME_BITS-2:0], sd_sync_reg}; // RQ10 RQ12
      end
    end
  end

  // Result hand-off; power-up and wake-up results are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      push_reg <= 1'b0;
      discard_reg <= 1'b1;
      ready_reg <= 1'b0;
    end else if (clk_en) begin
      push_reg <= 1'b0;
      ready_reg <= (state_reg == HST_IDLE) && !take && fifo_in_ready && !push_reg;
      if (state_reg == HST_QUIET && tick) begin
        if (shdn_frame_reg) begin
          discard_reg <= 1'b1; // RQ23
        end else begin
          push_reg <= !discard_reg; // RQ23
          discard_reg <= 1'b0;
        end
      end
    end
  end

  adcr_fifo #(
    .WIDTH(RES_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .in_data(capture_reg[RES_W-1:0]), // RQ24
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign conv_ready = ready_reg;

endmodule
`default_nettype wire

//--- src/adcr_link_if.sv
/*
  Three-wire link between the converter end and the host end.
  Assumes the result wire reads low while nobody drives it.
*/
`timescale 1ns/1ns
`default_nettype none
interface adcr_link_if;
  logic cs_n;
  logic sclk;
  logic serial_result_out_o;
  logic serial_result_out_oe;
  logic serial_result_out_line;

  // Undriven wire modelled as low
  assign serial_result_out_line = serial_result_out_oe ? serial_result_out_o : 1'b0;

  modport device (
    input cs_n,
    input sclk,
    output serial_result_out_o,
    output serial_result_out_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input serial_result_out_line
  );
endinterface
`default_nettype wire

//--- src/adcr_pkg.sv
/*
  Shared constants for the serial converter readout link: frame layout,
  edge numbers, timing figures and state encodings.
  Assumes a 100 MHz core clock on both ends.
*/
package adcr_pkg;
  localparam int RESULT_BITS = 12;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] GLITCH_FALLS = 5'h02;
  localparam logic [CNT_W-1:0] NORMAL_KEEP_FALLS = 5'h0A;
  localparam logic [CNT_W-1:0] HOLD_RELEASE_RISE = 5'h0D;
  localparam logic [CNT_W-1:0] FRAME_FALLS = 5'h10;
  localparam logic [CNT_W-1:0] HOST_FRAME_CLKS = 5'h14;
  localparam logic [CNT_W-1:0] SHDN_FRAME_FALLS = 5'h04;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int ACQ_TIME_NS = 350;
  localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_TIME_NS = 50;
  localparam int QUIET_CYC = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_HOLD = 2'h1,
    DEV_TRACK = 2'h3,
    DEV_DONE = 2'h2
  } adcr_dev_state_type;

  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_CLOCKING = 2'h1,
    HST_QUIET = 2'h3
  } adcr_host_state_type;
endpackage

//--- verification/adc_serial_readout_and_power_mode_test.sv
/*
  Bench joining host end and converter end over the link interface.
  Assumes the host end makes the serial clock; frames are judged on the wire,
  in the result FIFO and in the mode flags.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_serial_readout_and_power_mode_test
  import adcr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [11:0] sample_code = 12'h000;
  logic conv_req = 1'b0;
  logic conv_shutdown = 1'b0;
  logic result_ready = 1'b0;
  logic sample_taken, hold_active, shutdown_active, result_invalid, frame_aborted;
  logic conv_ready, result_valid;
  logic [11:0] result_data;
  logic sclk_d = 1'b1, cs_d = 1'b1, hold_d = 1'b0;
  logic [15:0] cap_word = 16'h0000;
  logic [4:0] cap_n = 5'h00, rise_n = 5'h00, hold_rises = 5'h00;
  logic [3:0] taken_n = 4'h0, abort_n = 4'h0;
  int num_errors = 0, n_compared = 0, cyc = 0;

  initial forever #5 core_clk = ~core_clk;

  adcr_link_if adcr_link_if_i ();
  adcr_device adcr_device_i (.core_clk, .rst, .clk_en, .link(adcr_link_if_i), .sample_code, .sample_taken,
    .hold_active, .shutdown_active, .result_invalid, .frame_aborted);
  adcr_host adcr_host_i (.core_clk, .rst, .clk_en, .link(adcr_link_if_i), .conv_req, .conv_shutdown,
    .conv_ready, .result_valid, .result_ready, .result_data);
  adcr_link_monitor adcr_link_monitor_i (.core_clk, .rst, .cs_n(adcr_link_if_i.cs_n), .sclk(adcr_link_if_i.sclk),
    .serial_result_out_o(adcr_link_if_i.serial_result_out_o), .serial_result_out_oe(adcr_link_if_i.serial_result_out_oe), .serial_result_out_line(adcr_link_if_i.serial_result_out_line));

  // Own capture of the wire, independent of the host end
  always @(posedge core_clk) begin
    sclk_d <= adcr_link_if_i.sclk;
    cs_d <= adcr_link_if_i.cs_n;
    hold_d <= hold_active;
    if (hold_d && !hold_active) hold_rises <= rise_n;
    // Pulse counts restart with each selection
    if (cs_d && !adcr_link_if_i.cs_n) begin
      taken_n <= 4'h0;
      abort_n <= 4'h0;
    end else begin
      if (sample_taken) taken_n <= taken_n + 4'h1;
      if (frame_aborted) abort_n <= abort_n + 4'h1;
    end
    if (cs_d && !adcr_link_if_i.cs_n) begin
      cap_n <= 5'h00;
      rise_n <= 5'h00;
    end else if (!adcr_link_if_i.cs_n && sclk_d != adcr_link_if_i.sclk) begin
      if (adcr_link_if_i.sclk) rise_n <= rise_n + 5'h01;
      else if (cap_n < 5'h10) begin
        cap_word <= {cap_word[14:0], adcr_link_if_i.serial_result_out_line};
        cap_n <= cap_n + 5'h01;
      end
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One request, then wait out the frame and the quiet time
  task automatic go(input logic shut);
    int n;
    n = 0;
    while (conv_ready !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    conv_req = 1'b1;
    conv_shutdown = shut;
    @(negedge core_clk);
    conv_req = 1'b0;
    n = 0;
    while (adcr_link_if_i.cs_n !== 1'b0 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    check("select", 16'(adcr_link_if_i.cs_n), 16'h0000);
    n = 0;
    while (adcr_link_if_i.cs_n !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    repeat (50) @(negedge core_clk);
  endtask

  task automatic pop(input logic [11:0] exp);
    check("result_valid", 16'(result_valid), 16'h0001);
    check("result_data", 16'(result_data), 16'(exp));
    result_ready = 1'b1;
    @(negedge core_clk);
    result_ready = 1'b0;
  endtask

  task automatic after_reset();
    check("cs_idle", 16'(adcr_link_if_i.cs_n), 16'h0001);
    check("oe_idle", 16'(adcr_link_if_i.serial_result_out_oe), 16'h0000);
    go(1'b0);
    check("dummy_dropped", 16'(result_valid), 16'h0000);
  endtask

  task automatic read_check(input logic [11:0] code);
    sample_code = code;
    go(1'b0);
    check("wire_frame", cap_word, {4'h0, code});
    check("hold_rises", 16'(hold_rises), 16'h000D);
    check("oe_after", 16'(adcr_link_if_i.serial_result_out_oe), 16'h0000);
    check("mode_normal", 16'(shutdown_active), 16'h0000);
    check("taken_once", 16'(taken_n), 16'h0001);
    check("no_abort", 16'(abort_n), 16'h0000);
    check("valid_result", 16'(result_invalid), 16'h0000);
    pop(code);
  endtask

  task automatic shutdown_seq();
    sample_code = 12'h3C7;
    go(1'b1);
    check("shut_mode", 16'(shutdown_active), 16'h0001);
    check("shut_falls", 16'(cap_n), 16'h0004);
    check("shut_float", 16'(adcr_link_if_i.serial_result_out_oe), 16'h0000);
    check("shut_noresult", 16'(result_valid), 16'h0000);
    check("shut_abort", 16'(abort_n), 16'h0001);
    // Long idle: no minimum rate, mode must hold
    repeat (200) @(negedge core_clk);
    check("shut_stays", 16'(shutdown_active), 16'h0001);
    go(1'b0);
    check("wake_mode", 16'(shutdown_active), 16'h0000);
    check("wake_invalid", 16'(result_invalid), 16'h0001);
    check("wake_dropped", 16'(result_valid), 16'h0000);
    read_check(12'h5A3);
  endtask

  // Enable low mid-frame: both ends stand still, the frame then completes intact
  task automatic freeze_check();
    logic held_sclk;
    int n;
    sample_code = 12'h6B1;
    conv_shutdown = 1'b0;
    conv_req = 1'b1;
    n = 0;
    while (adcr_link_if_i.cs_n !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    conv_req = 1'b0;
    repeat (100) @(negedge core_clk);
    clk_en = 1'b0;
    held_sclk = adcr_link_if_i.sclk;
    repeat (40) @(negedge core_clk);
    check("freeze_sclk", 16'(adcr_link_if_i.sclk), 16'(held_sclk));
    check("freeze_cs", 16'(adcr_link_if_i.cs_n), 16'h0000);
    clk_en = 1'b1;
    n = 0;
    while (adcr_link_if_i.cs_n !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    repeat (50) @(negedge core_clk);
    check("freeze_frame", cap_word, 16'h06B1);
    pop(12'h6B1);
  endtask

  // Fill the result FIFO until requests are refused, then drain in order
  task automatic fifo_fill();
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      sample_code = 12'(i * 273);
      go(1'b0);
    end
    check("full_refused", 16'(conv_ready), 16'h0000);
    for (int i = 0; i < FIFO_DEPTH; i++) pop(12'(i * 273));
    check("drained", 16'(result_valid), 16'h0000);
  endtask

  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    after_reset();
    read_check(12'hFFF);
    read_check(12'h000);
    read_check(12'hA5C);
    freeze_check();
    shutdown_seq();
    fifo_fill();
    print_verdict();
  end
endmodule
`default_nettype wire

//--- verification/adcr_link_monitor.sv
/*
  Checker for the readout link wires between host end and converter end.
  Assumes it sees the shared link signals and the core clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module adcr_link_monitor
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_result_out_o,
  input wire logic serial_result_out_oe,
  input wire logic serial_result_out_line
);
  logic sclk_d_reg, cs_d_reg, sclk_fall;
  logic [4:0] falls_reg;
  logic [3:0] since_reg;
  logic [7:0] high_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Falls only count inside a frame
  assign sclk_fall = sclk_d_reg && !sclk && !cs_n;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= 1'b1;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk;
      cs_d_reg <= cs_n;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) falls_reg <= 5'h00;
    else if (cs_n) falls_reg <= 5'h00;
    else if (sclk_fall && falls_reg != 5'h1F) falls_reg <= falls_reg + 5'h01;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) since_reg <= 4'hF;
    else if (sclk_fall || (cs_d_reg && !cs_n)) since_reg <= 4'h0;
    else if (since_reg != 4'hF) since_reg <= since_reg + 4'h1;
  end

  // Saturated at reset so the first request is not flagged
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) high_reg <= 8'hFF;
    else if (!cs_n) high_reg <= 8'h00;
    else if (high_reg != 8'hFF) high_reg <= high_reg + 8'h01;
  end

  a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:6] serial_result_out_oe)
    else $error("result output not driven after select");
  a_oe_off_deselect: assert property ($rose(cs_n) |-> ##[1:6] !serial_result_out_oe)
    else $error("result output still driven after deselect");
  a_oe_off_sixteen: assert property (sclk_fall && falls_reg == 5'h0F |-> ##[1:6] !serial_result_out_oe)
    else $error("result output still driven after last bit");
  a_bit_on_fall: assert property (serial_result_out_oe && $changed(serial_result_out_o) |-> since_reg <= 4'h6)
    else $error("result bit changed away from a clock fall");
  a_lead_zeros: assert property (!cs_n && falls_reg <= 5'h03 |-> !serial_result_out_line)
    else $error("leading bit not zero");
  a_clk_idle_high: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("serial clock moves outside a frame");
  a_clk_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  a_frame_fall_count: assert property ($rose(cs_n) |-> falls_reg == HOST_FRAME_CLKS || falls_reg == SHDN_FRAME_FALLS)
    else $error("frame ended with an unexpected number of falls");
  a_quiet_gap: assert property ($fell(cs_n) |-> high_reg >= 8'(ACQ_CYC))
    else $error("next select came too soon");

  c_read_frame: cover property ($rose(cs_n) && falls_reg == HOST_FRAME_CLKS);
  c_shut_frame: cover property ($rose(cs_n) && falls_reg == SHDN_FRAME_FALLS);
  c_data_one: cover property (serial_result_out_oe && serial_result_out_line);
endmodule
`default_nettype wire
